// >>> core/mbd_decoder.v
// Module bus address extension, map decode and RAM placement
//
// Behaviour
// - Upper four bus lines copy core bit 19
// - Bus uses 16 data, 20 significant address
// - Upper address copy driven to test pins
// - Range 080000 to F7FFFF selects nothing
// - RAM array placed by programmable base register
// - Reset leaves both RAM arrays disabled
// - Unimplemented addresses go to external bus
// - Module block nibble is map bit then 111
// - Map bit cleared hides all modules
// - Map bit takes only first write
// - Microcode RAM control at offsets D00-D3F
// - Standby RAM control at offsets B00-B3F
// - Bases allow arrays to sit contiguously
// - ROM emulation select held high always
// - Program and data spaces both 1 Mbyte
// - Space code lines mark access space
`timescale 1ns/1ps
`default_nettype none
`include "mbd_consts.vh"

module mbd_decoder #(
   parameter ADDR_W = 20,
   parameter DATA_W = 16,
   parameter RAM_AW = 11
) (
   input wire clk,
   input wire reset,
   input wire [ADDR_W-1:0] core_addr,
   input wire core_req,
   input wire core_rw,
   input wire [2:0] space_code_lines,
   input wire [3:0] reg_addr,
   input wire [DATA_W-1:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [DATA_W-1:0] reg_rdata,
   output reg [23:0] bus_addr_ff,
   output reg bus_rw_ff,
   output reg bus_valid_ff,
   output reg [3:0] test_addr_hi_ff,
   output reg [2:0] space_code_out_ff,
   output reg prog_space_ff,
   output reg data_space_ff,
   output reg sel_no_access_ff,
   output reg sel_module_ff,
   output reg sel_mc_ctl_ff,
   output reg sel_sb_ctl_ff,
   output reg sel_mc_array_ff,
   output reg sel_sb_array_ff,
   output reg sel_external_ff,
   output reg rom_emulation_select_ff,
   output reg rom_fn_selected_ff
);

   localparam BASE_W = 24 - RAM_AW;

   reg map_position_bit_ff;
   reg map_locked_ff;
   reg rom_fn_ff;
   reg [BASE_W-1:0] mc_base_ff;
   reg [BASE_W-1:0] sb_base_ff;
   reg mc_en_ff;
   reg sb_en_ff;

   reg [23:0] ext_addr;
   reg no_access;
   reg mod_hit;
   reg mc_hit;
   reg sb_hit;
   reg cpu_space;
   reg [DATA_W-1:0] nxt_rdata;

   // Array hit against a base aligned to the array size
   function ram_hit;
      input [23:0] a;
      input [BASE_W-1:0] base;
      input en;
      begin
         ram_hit = en && (a[23:RAM_AW] == base);
      end
   endfunction

   function [DATA_W-1:0] base_word;
      input [BASE_W-1:0] base;
      begin
         base_word = {{(DATA_W-BASE_W){1'b0}}, base};
      end
   endfunction

   // Address extension and decode
   always @* begin
      ext_addr = {{4{core_addr[ADDR_W-1]}}, core_addr};
      no_access = (ext_addr >= `MBD_NOACC_LO) &&
         (ext_addr <= `MBD_NOACC_HI);
      cpu_space = (space_code_lines == `MBD_FC_CPU);
      mod_hit = map_position_bit_ff &&
         (ext_addr[23:20] == {map_position_bit_ff, `MBD_MOD_LOW_NIB}) &&
         (ext_addr[19:12] == `MBD_MOD_PAGE);
      mc_hit = ram_hit(ext_addr, mc_base_ff, mc_en_ff);
      sb_hit = ram_hit(ext_addr, sb_base_ff, sb_en_ff);
   end

   always @(posedge clk or posedge reset) begin
      if (reset) begin
         bus_addr_ff <= 24'h000000;
         bus_rw_ff <= 1'b1;
         bus_valid_ff <= 1'b0;
         test_addr_hi_ff <= 4'h0;
         space_code_out_ff <= 3'h0;
         prog_space_ff <= 1'b0;
         data_space_ff <= 1'b0;
         sel_no_access_ff <= 1'b0;
         sel_module_ff <= 1'b0;
         sel_mc_ctl_ff <= 1'b0;
         sel_sb_ctl_ff <= 1'b0;
         sel_mc_array_ff <= 1'b0;
         sel_sb_array_ff <= 1'b0;
         sel_external_ff <= 1'b0;
      end else begin
         bus_valid_ff <= core_req;
         if (core_req) begin
            bus_addr_ff <= ext_addr;
            bus_rw_ff <= core_rw;
            test_addr_hi_ff <= ext_addr[23:20];
            space_code_out_ff <= space_code_lines;
            // Both spaces share the same 20-bit map
            prog_space_ff <= (space_code_lines[1:0] == `MBD_FC_PROG);
            data_space_ff <= (space_code_lines[1:0] == `MBD_FC_DATA);
         end
         // Selects last one cycle per request; CPU space selects nothing
         sel_no_access_ff <= core_req && !cpu_space && no_access;
         sel_module_ff <= core_req && !cpu_space && !no_access && mod_hit;
         sel_mc_ctl_ff <= core_req && !cpu_space && !no_access && mod_hit &&
            (ext_addr[11:6] == `MBD_MC_CTL_BLK);
         sel_sb_ctl_ff <= core_req && !cpu_space && !no_access && mod_hit &&
            (ext_addr[11:6] == `MBD_SB_CTL_BLK);
         // Overlapping arrays both answer; software keeps them apart
         sel_mc_array_ff <= core_req && !cpu_space && !no_access &&
            !mod_hit && mc_hit;
         sel_sb_array_ff <= core_req && !cpu_space && !no_access &&
            !mod_hit && sb_hit;
         sel_external_ff <= core_req && !cpu_space && !no_access &&
            !mod_hit && !mc_hit && !sb_hit;
      end
   end

   // Register writes
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         map_position_bit_ff <= `MBD_RST_MAP;
         map_locked_ff <= 1'b0;
         rom_fn_ff <= `MBD_RST_ROM_FN;
         mc_base_ff <= `MBD_RST_BASE;
         sb_base_ff <= `MBD_RST_BASE;
         mc_en_ff <= `MBD_RST_EN;
         sb_en_ff <= `MBD_RST_EN;
      end else if (reg_wr) begin
         case (reg_addr)
            `MBD_OFS_CFG: begin
               rom_fn_ff <= reg_wdata[`MBD_CFG_ROM_FN_BIT];
               if (!map_locked_ff) begin
                  map_position_bit_ff <= reg_wdata[`MBD_CFG_MAP_BIT];
                  map_locked_ff <= 1'b1;
               end
            end
            `MBD_OFS_MC_BASE: mc_base_ff <= reg_wdata[BASE_W-1:0];
            `MBD_OFS_MC_CTL: mc_en_ff <= reg_wdata[`MBD_CTL_EN_BIT];
            `MBD_OFS_SB_BASE: sb_base_ff <= reg_wdata[BASE_W-1:0];
            `MBD_OFS_SB_CTL: sb_en_ff <= reg_wdata[`MBD_CTL_EN_BIT];
            default: begin
            end
         endcase
      end
   end

   // Read data, one cycle after the read strobe
   always @* begin
      nxt_rdata = {DATA_W{1'b0}};
      case (reg_addr)
         `MBD_OFS_CFG: begin
            nxt_rdata[`MBD_CFG_MAP_BIT] = map_position_bit_ff;
            nxt_rdata[`MBD_CFG_ROM_FN_BIT] = rom_fn_ff;
         end
         `MBD_OFS_MC_BASE: nxt_rdata = base_word(mc_base_ff);
         `MBD_OFS_MC_CTL: nxt_rdata[`MBD_CTL_EN_BIT] = mc_en_ff;
         `MBD_OFS_SB_BASE: nxt_rdata = base_word(sb_base_ff);
         `MBD_OFS_SB_CTL: nxt_rdata[`MBD_CTL_EN_BIT] = sb_en_ff;
         `MBD_OFS_STATUS: begin
            nxt_rdata[`MBD_ST_MAP_BIT] = map_position_bit_ff;
            nxt_rdata[`MBD_ST_LOCK_BIT] = map_locked_ff;
            // Module block sits at nibble F only with the map bit set
            nxt_rdata[`MBD_ST_MAP_OK_BIT] = map_position_bit_ff;
         end
         `MBD_OFS_LAST_ADDR_LO: nxt_rdata = bus_addr_ff[15:0];
         `MBD_OFS_LAST_ADDR_HI: nxt_rdata = {8'h00, bus_addr_ff[23:16]};
         default: nxt_rdata = {DATA_W{1'b0}};
      endcase
   end

   always @(posedge clk or posedge reset) begin
      if (reset) begin
         reg_rdata <= {DATA_W{1'b0}};
      end else if (reg_rd) begin
         reg_rdata <= nxt_rdata;
      end else begin
         reg_rdata <= {DATA_W{1'b0}};
      end
   end

   // No ROM array: select pin stays high, never asserts on ROM addresses
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         rom_emulation_select_ff <= 1'b1;
         rom_fn_selected_ff <= 1'b0;
      end else begin
         rom_emulation_select_ff <= 1'b1;
         rom_fn_selected_ff <= rom_fn_ff;
      end
   end

endmodule // mbd_decoder

`default_nettype wire

// >>> include/mbd_consts.vh
// Constants for the module bus address decoder
`ifndef MBD_CONSTS_VH
`define MBD_CONSTS_VH

// Register port offsets (word index)
`define MBD_OFS_CFG 4'h0
`define MBD_OFS_MC_BASE 4'h1
`define MBD_OFS_MC_CTL 4'h2
`define MBD_OFS_SB_BASE 4'h3
`define MBD_OFS_SB_CTL 4'h4
`define MBD_OFS_STATUS 4'h5
`define MBD_OFS_LAST_ADDR_LO 4'h6
`define MBD_OFS_LAST_ADDR_HI 4'h7

// Configuration register fields
`define MBD_CFG_MAP_BIT 15
`define MBD_CFG_ROM_FN_BIT 0

// RAM control register field
`define MBD_CTL_EN_BIT 0

// Status register fields
`define MBD_ST_MAP_BIT 0
`define MBD_ST_LOCK_BIT 1
`define MBD_ST_MAP_OK_BIT 2

// Reset values
`define MBD_RST_MAP 1'b1
`define MBD_RST_ROM_FN 1'b0
`define MBD_RST_BASE 13'h0000
`define MBD_RST_EN 1'b0

// Address map
`define MBD_NOACC_LO 24'h080000
`define MBD_NOACC_HI 24'hf7ffff
`define MBD_MOD_LOW_NIB 3'b111
`define MBD_MOD_PAGE 8'hff
`define MBD_MC_CTL_BLK 6'h34
`define MBD_SB_CTL_BLK 6'h2c

// Space codes
`define MBD_FC_DATA 2'b01
`define MBD_FC_PROG 2'b10
`define MBD_FC_CPU 3'b111

`endif

// >>> tb/mbd_checker.sv
// Concurrent checks on the decoder ports
`timescale 1ns/1ps
`default_nettype none
module mbd_checker (
   input wire logic clk,
   input wire logic reset,
   input wire logic [19:0] core_addr,
   input wire logic core_req,
   input wire logic [2:0] space_code_lines,
   input wire logic [23:0] bus_addr_ff,
   input wire logic [3:0] test_addr_hi_ff,
   input wire logic [2:0] space_code_out_ff,
   input wire logic sel_no_access_ff,
   input wire logic sel_module_ff,
   input wire logic sel_mc_ctl_ff,
   input wire logic sel_sb_ctl_ff,
   input wire logic sel_external_ff,
   input wire logic rom_emulation_select_ff
);
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   a_upper_copy: assert property (
      core_req |=> bus_addr_ff == {{4{$past(core_addr[19])}},
      $past(core_addr)}) else $error("upper address lines not copied");
   a_test_pins: assert property (
      core_req |=> test_addr_hi_ff == {4{$past(core_addr[19])}})
      else $error("test pins wrong");
   a_no_access: assert property (!sel_no_access_ff)
      else $error("hole range selected");
   a_module_nib: assert property (
      sel_module_ff |-> bus_addr_ff[23:12] == 12'hfff)
      else $error("module block outside top page");
   a_mc_ctl_ofs: assert property (
      sel_mc_ctl_ff |-> sel_module_ff && bus_addr_ff[11:6] == 6'h34)
      else $error("microcode ram control offset wrong");
   a_sb_ctl_ofs: assert property (
      sel_sb_ctl_ff |-> sel_module_ff && bus_addr_ff[11:6] == 6'h2c)
      else $error("standby ram control offset wrong");
   a_ext_alone: assert property (
      sel_external_ff |-> !sel_module_ff && !sel_no_access_ff)
      else $error("external select overlaps internal");
   a_rom_high: assert property (rom_emulation_select_ff)
      else $error("rom emulation select not high");
   a_space_code: assert property (
      core_req |=> space_code_out_ff == $past(space_code_lines))
      else $error("space code not passed on");
endmodule // mbd_checker
bind mbd_decoder mbd_checker u_mbd_checker (.*);
`default_nettype wire

// >>> tb/mbd_core_model.sv
// Core-side model that issues module bus accesses
`timescale 1ns/1ps
`default_nettype none
module mbd_core_model (
   input wire logic clk,
   output var logic [19:0] core_addr = 20'h00000,
   output var logic core_req = 1'b0,
   output var logic core_rw = 1'b1,
   output var logic [2:0] space_code_lines = 3'h0
);
   // Idle lines invert so a stale address is never trusted
   task automatic access(input logic [19:0] a, input logic [2:0] fc);
      @(posedge clk);
      core_req <= 1'b1;
      core_rw <= a[0];
      core_addr <= a;
      space_code_lines <= fc;
      @(posedge clk);
      core_req <= 1'b0;
      core_addr <= ~a;
      space_code_lines <= ~fc;
   endtask
endmodule // mbd_core_model
`default_nettype wire

// >>> tb/test_mbd_decoder.sv
// Self-checking bench for the module bus address decoder
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin fail_count++; \
   $display("mismatch %s exp %h got %h", n, e, s); end end
module test_mbd_decoder;
   logic clk = 1'b0, reset = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
   logic core_req, core_rw, bus_rw_ff, bus_valid_ff, prog_space_ff;
   logic data_space_ff, sel_no_access_ff, sel_module_ff, sel_mc_ctl_ff;
   logic sel_sb_ctl_ff, sel_mc_array_ff, sel_sb_array_ff, sel_external_ff;
   logic rom_emulation_select_ff, rom_fn_selected_ff;
   logic [19:0] core_addr;
   logic [2:0] space_code_lines, space_code_out_ff;
   logic [3:0] reg_addr = 4'h0, test_addr_hi_ff;
   logic [15:0] reg_wdata = 16'h0000, reg_rdata;
   logic [23:0] bus_addr_ff;
   int fail_count = 0, checks = 0;
   // Rows: core address, space code, selects {mod,mcc,sbc,mca,sba,ext}
   logic [28:0] rows [8] = '{{20'hffd00, 3'h5, 6'h30},
      {20'hffb3e, 3'h5, 6'h28}, {20'hffd40, 3'h6, 6'h20},
      {20'h00100, 3'h1, 6'h01}, {20'h7ffff, 3'h2, 6'h01},
      {20'hfe000, 3'h5, 6'h01}, {20'h80000, 3'h1, 6'h01},
      {20'hffd00, 3'h7, 6'h00}};
   wire [5:0] sel = {sel_module_ff, sel_mc_ctl_ff, sel_sb_ctl_ff,
      sel_mc_array_ff, sel_sb_array_ff, sel_external_ff};
   mbd_decoder u_mbd_decoder (.*);
   mbd_core_model u_mbd_core_model (.*);
   initial forever #2.5 clk = ~clk;
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [15:0] e);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      `CHK("rdata", e, reg_rdata)
   endtask
   task automatic acc(input logic [28:0] r);
      u_mbd_core_model.access(r[28:9], r[8:6]);
      #1;
      `CHK("sel", r[5:0], sel)
      `CHK("addr", {{4{r[28]}}, r[28:9]}, bus_addr_ff)
      `CHK("prog", r[7:6] == 2'b10, prog_space_ff)
      `CHK("data", r[7:6] == 2'b01, data_space_ff)
      `CHK("valid", 1'b1, bus_valid_ff)
      `CHK("rw", r[9], bus_rw_ff)
   endtask
   task automatic close_out;
      if (fail_count == 0 && checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      #100000;
      fail_count++;
      close_out;
   end
   initial begin
      repeat (12) @(posedge clk);
      reset <= 1'b0;
      rd(4'h5, 16'h0005);
      rd(4'h8, 16'h0000);
      foreach (rows[i]) acc(rows[i]);
      // Standby array at 000800, microcode array right above it
      wr(4'h3, 16'h0001);
      wr(4'h1, 16'h0002);
      wr(4'h4, 16'h0001);
      wr(4'h2, 16'h0001);
      rd(4'h1, 16'h0002);
      acc({20'h00800, 3'h1, 6'h02});
      acc({20'h017fe, 3'h1, 6'h04});
      wr(4'h0, 16'h0000);
      wr(4'h0, 16'h8001);
      acc({20'hffd00, 3'h5, 6'h01});
      rd(4'h5, 16'h0002);
      `CHK("romfn", 1'b1, rom_fn_selected_ff)
      @(posedge clk);
      reset <= 1'b1;
      @(posedge clk);
      reset <= 1'b0;
      rd(4'h5, 16'h0005);
      acc(rows[0]);
      close_out;
   end
endmodule // test_mbd_decoder
`default_nettype wire
